// ---- logic/tic_pkg.sv ----
/*
 * shared constants and types of the timer input capture block:
 * register offsets, control field positions, reset values, mode and
 * sequencer encodings, and the packed carriers used between files.
 * assumes an 8-bit register port and a single instruction clock.
 */
`default_nettype none

package tic_pkg;

    // widths of the register port and of the timer
    localparam int TIC_DATA_W = 8;
    localparam int TIC_ADDR_W = 3;
    localparam int TIC_CNT_W  = 16;

    // register offsets on the register port
    localparam logic [2:0] TIC_OFS_CTRL   = 3'h0;
    localparam logic [2:0] TIC_OFS_CNT_LO = 3'h1;
    localparam logic [2:0] TIC_OFS_CNT_HI = 3'h2;
    localparam logic [2:0] TIC_OFS_CAP_LO = 3'h3;
    localparam logic [2:0] TIC_OFS_CAP_HI = 3'h4;

    // field positions inside the timer control register
    localparam int TIC_BIT_MODE_HI = 7;
    localparam int TIC_BIT_MODE_LO = 6;
    localparam int TIC_BIT_EDGE    = 5;
    localparam int TIC_BIT_UFL     = 4;
    localparam int TIC_BIT_CAPPND  = 3;
    localparam int TIC_BIT_IRQEN   = 2;

    // values after reset
    localparam logic [7:0]  TIC_CTRL_RST = 8'h00;
    localparam logic [15:0] TIC_CNT_RST  = 16'h0000;
    localparam logic [15:0] TIC_CAP_RST  = 16'h0000;
    localparam logic [7:0]  TIC_RD_RST   = 8'h00;

    // operating modes held in the two upper control bits
    typedef enum logic [1:0] {
        TIC_MODE_EVT  = 2'b00,
        TIC_MODE_CAP  = 2'b01,
        TIC_MODE_PWM  = 2'b10,
        TIC_MODE_DIFF = 2'b11
    } tic_mode_t;

    // difference capture sequencer, gray coded along idle-wait-run-wait
    typedef enum logic [1:0] {
        TIC_DIFF_IDLE = 2'b00,
        TIC_DIFF_WAIT = 2'b01,
        TIC_DIFF_RUN  = 2'b11
    } tic_diff_t;

    // one register port request
    typedef struct packed {
        logic [TIC_ADDR_W-1:0] addr;
        logic [TIC_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } tic_bus_req_t;

    // edge events from the pin synchroniser
    typedef struct packed {
        logic rise;
        logic fall;
    } tic_edge_t;

    // whole state of the capture block
    typedef struct packed {
        tic_mode_t             mode;
        logic                  edgeSel;
        logic                  ufl;
        logic                  capPnd;
        logic                  irqEn;
        logic                  endEdge;
        tic_diff_t             diff;
        logic [TIC_CNT_W-1:0]  cap;
        logic [TIC_DATA_W-1:0] rdata;
    } tic_state_t;

endpackage

`default_nettype wire

// ---- logic/tic_edge_detect.sv ----
/*
 * synchroniser and edge detector for the capture input pin.
 * assumes the pin is asynchronous to clk_sys and that every level
 * stays for at least one clock so no transition is lost.
 */
`timescale 1ns/1ps
`default_nettype none

module tic_edge_detect
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic      clk_sys,
    input  wire logic      rst_b,
    // pin and events
    input  wire logic      pinIn,
    output tic_edge_t      edges
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } tic_sync_state_t;

    tic_sync_state_t st;
    tic_sync_state_t next_st;

    // two-stage synchroniser, then one more sample to compare against
    always_comb begin
        next_st      = st;
        next_st.meta = pinIn;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // one pulse per transition, seen only by the synchronised stages
    assign edges.rise = st.sync & ~st.prev;
    assign edges.fall = ~st.sync & st.prev;

endmodule

`default_nettype wire

// ---- logic/tic_counter.sv ----
/*
 * up/down counter holding the timer count register.
 * assumes byte loads from software and count control from the
 * capture block on the same clock; wrap is flagged combinationally.
 */
`timescale 1ns/1ps
`default_nettype none

module tic_counter
    import tic_pkg::*;
#(
    parameter int WIDTH = TIC_CNT_W
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // software byte loads
    input  wire logic             loadLo,
    input  wire logic             loadHi,
    input  wire logic [7:0]       loadByte,
    // count control
    input  wire logic             countEn,
    input  wire logic             countUp,
    input  wire logic             clear,
    // state
    output logic      [WIDTH-1:0] count,
    output logic                  wrap
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } tic_cnt_state_t;

    tic_cnt_state_t st;
    tic_cnt_state_t next_st;

    // refuse widths that the byte loads cannot fill
    if (WIDTH != 16) begin : g_chk
        $error("tic_counter supports a width of 16 only");
    end

    // wrap happens when the next step crosses the end of the range;
    // a software load in that cycle wins, so no wrap is flagged then
    assign wrap = countEn & ~clear & ~loadLo & ~loadHi &
                  (countUp ? (&st.count) : (st.count == '0));

    // clear wins, then software loads, then counting
    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.count = '0;
        end else if (loadLo | loadHi) begin
            if (loadLo) begin
                next_st.count[7:0] = loadByte;
            end
            if (loadHi) begin
                next_st.count[15:8] = loadByte;
            end
        end else if (countEn) begin
            if (countUp) begin
                next_st.count = st.count + WIDTH'(1);
            end else begin
                next_st.count = st.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st.count <= TIC_CNT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;

endmodule

`default_nettype wire

// ---- logic/tic_capture.sv ----
/*
 * capture modes of a 16-bit multifunction timer: standard capture,
 * where a free down-count is copied on a selected pin edge, and
 * difference capture, where the time between two edges is counted up.
 * assumes an 8-bit register port with one-cycle strobes and read data
 * one cycle later, and an asynchronous capture pin.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - standard capture counts down every clock from selection, no run bit
// - selected pin edge copies count to capture register, sets capture flag
// - interrupt request only while the interrupt enable bit is set
// - capture modes keep a capture flag and an underflow flag
// - interrupt raised when a flag goes from clear to set
// - capture and underflow together set both flags at once, in standard capture only
// - in capture modes the start/stop bit is the underflow flag; on entry to difference capture it sets the end edge
// - edge select picks rising or falling, changeable while running
// - difference capture offers four start and end edge pairings
// - difference capture waits for first edge, then counts up each clock
// - second edge stops the count and stores the elapsed count
// - difference capture uses the same two flags
// - mode 0,1 selects standard capture; third bit 0 rising, 1 falling
// - mode 1,1 selects difference capture; third and fourth bits pick the edges
module tic_capture
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // register port
    input  wire tic_bus_req_t          busReq,
    output logic      [TIC_DATA_W-1:0] rdData,
    // capture input pin
    input  wire logic                  capturePin,
    // interrupt toward the core
    output logic                       timerIntReq
);

    // the register map below is laid out for byte-wide data
    if (TIC_DATA_W != 8 || TIC_CNT_W != 16) begin : g_chk
        $error("tic_capture needs 8-bit data and a 16-bit timer");
    end

    tic_state_t           st;
    tic_state_t           next_st;
    tic_edge_t            edges;
    logic [TIC_CNT_W-1:0] count;
    logic                 wrap;
    logic                 cntEn;
    logic                 cntUp;
    logic                 cntClear;
    logic                 loadLo;
    logic                 loadHi;

    // a mode is of the capture kind when its low mode bit is set
    function automatic logic is_capture(input tic_mode_t m);
        is_capture = (m == TIC_MODE_CAP) || (m == TIC_MODE_DIFF);
    endfunction

    // pick the rising or falling event by a select bit
    function automatic logic pick_edge(input tic_edge_t e,
                                       input logic      fallSel);
        pick_edge = fallSel ? e.fall : e.rise;
    endfunction

    // pin synchroniser and edge detector
    tic_edge_detect u_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pinIn   (capturePin),
        .edges   (edges)
    );

    // the timer count register itself
    tic_counter #(
        .WIDTH (TIC_CNT_W)
    ) u_count (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .loadLo   (loadLo),
        .loadHi   (loadHi),
        .loadByte (busReq.wdata),
        .countEn  (cntEn),
        .countUp  (cntUp),
        .clear    (cntClear),
        .count    (count),
        .wrap     (wrap)
    );

    // software byte writes to the count register
    assign loadLo = busReq.wr & (busReq.addr == TIC_OFS_CNT_LO);
    assign loadHi = busReq.wr & (busReq.addr == TIC_OFS_CNT_HI);

    // counter steering: down in standard capture, up while a gap runs
    always_comb begin
        cntEn    = 1'b0;
        cntUp    = 1'b0;
        cntClear = 1'b0;
        case (st.mode)
            TIC_MODE_CAP: begin
                cntEn = 1'b1;
            end
            TIC_MODE_DIFF: begin
                cntUp = 1'b1;
                if (st.diff == TIC_DIFF_WAIT) begin
                    cntClear = pick_edge(edges, st.edgeSel);
                end else if (st.diff == TIC_DIFF_RUN) begin
                    cntEn = ~pick_edge(edges, st.endEdge);
                end
            end
            default: begin
                // other modes leave the count still, whatever the start/stop bit holds
                cntEn = 1'b0;
            end
        endcase
    end

    // register writes first, then hardware events so that a set wins
    always_comb begin
        logic      wrCtrl;
        logic      enterCap;
        tic_mode_t newMode;
        wrCtrl   = 1'b0;
        enterCap = 1'b0;
        newMode  = st.mode;
        next_st  = st;

        // software side of the control register
        wrCtrl = busReq.wr & (busReq.addr == TIC_OFS_CTRL);
        if (wrCtrl) begin
            newMode = tic_mode_t'(busReq.wdata[TIC_BIT_MODE_HI:
                                                TIC_BIT_MODE_LO]);
            enterCap = is_capture(newMode) && !is_capture(st.mode);
            next_st.mode    = newMode;
            next_st.edgeSel = busReq.wdata[TIC_BIT_EDGE];
            next_st.irqEn   = busReq.wdata[TIC_BIT_IRQEN];
            // capture flag: zero clears, one keeps
            next_st.capPnd = st.capPnd
                             & busReq.wdata[TIC_BIT_CAPPND];
            if (!is_capture(newMode)) begin
                // outside capture the bit is a plain start/stop bit
                next_st.ufl = busReq.wdata[TIC_BIT_UFL];
            end else if (enterCap) begin
                // on entry the bit carries setup, the flag starts clear
                next_st.ufl = 1'b0;
            end else begin
                next_st.ufl = st.ufl & busReq.wdata[TIC_BIT_UFL];
            end
            // the end edge is taken once, when difference mode is entered
            if (newMode == TIC_MODE_DIFF && st.mode != TIC_MODE_DIFF) begin
                next_st.endEdge = busReq.wdata[TIC_BIT_UFL];
            end
        end

        // standard capture: copy the down-count on the selected edge
        if (st.mode == TIC_MODE_CAP) begin
            if (pick_edge(edges, st.edgeSel)) begin
                next_st.cap    = count;
                next_st.capPnd = 1'b1;
            end
        end

        // difference capture sequencer
        case (st.diff)
            TIC_DIFF_IDLE: begin
                if (st.mode == TIC_MODE_DIFF) begin
                    next_st.diff = TIC_DIFF_WAIT;
                end
            end
            TIC_DIFF_WAIT: begin
                // start edge of the pair clears the counter and starts it
                if (pick_edge(edges, st.edgeSel)) begin
                    next_st.diff = TIC_DIFF_RUN;
                end
            end
            TIC_DIFF_RUN: begin
                // end edge stores the elapsed count and stops counting
                if (pick_edge(edges, st.endEdge)) begin
                    next_st.cap    = count;
                    next_st.capPnd = 1'b1;
                    next_st.diff   = TIC_DIFF_WAIT;
                end
            end
            default: begin
                next_st.diff = TIC_DIFF_IDLE;
            end
        endcase
        if (st.mode != TIC_MODE_DIFF) begin
            next_st.diff = TIC_DIFF_IDLE;
        end

        // underflow flag, set on a wrap in both capture modes, beside a capture in standard capture only
        if (is_capture(st.mode) && wrap) begin
            next_st.ufl = 1'b1;
        end

        // read data stands only in the cycle after the read strobe
        next_st.rdata = TIC_RD_RST;
        if (busReq.rd) begin
            case (busReq.addr)
                TIC_OFS_CTRL: begin
                    next_st.rdata = {st.mode, st.edgeSel, st.ufl,
                                     st.capPnd, st.irqEn, 2'b00};
                end
                TIC_OFS_CNT_LO: begin
                    next_st.rdata = count[7:0];
                end
                TIC_OFS_CNT_HI: begin
                    next_st.rdata = count[15:8];
                end
                TIC_OFS_CAP_LO: begin
                    next_st.rdata = st.cap[7:0];
                end
                TIC_OFS_CAP_HI: begin
                    next_st.rdata = st.cap[15:8];
                end
                default: begin
                    next_st.rdata = TIC_RD_RST; // unmapped reads as zero
                end
            endcase
        end
    end

    // all block state in one register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st.mode    <= TIC_MODE_EVT;
            st.edgeSel <= TIC_CTRL_RST[TIC_BIT_EDGE];
            st.ufl     <= TIC_CTRL_RST[TIC_BIT_UFL];
            st.capPnd  <= TIC_CTRL_RST[TIC_BIT_CAPPND];
            st.irqEn   <= TIC_CTRL_RST[TIC_BIT_IRQEN];
            st.endEdge <= 1'b0;
            st.diff    <= TIC_DIFF_IDLE;
            st.cap     <= TIC_CAP_RST;
            st.rdata   <= TIC_RD_RST;
        end else begin
            st <= next_st;
        end
    end

    // register outputs
    assign rdData = st.rdata;

    // level request while enabled and any pending flag stands; a new
    // request appears when a flag rises from clear or when enable is set with a flag pending
    assign timerIntReq = st.irqEn
                         & (st.capPnd
                            | (is_capture(st.mode) & st.ufl));

endmodule

`default_nettype wire

// ---- testbench/tic_capture_chk.sv ----
/*
 * port-side checker of the timer input capture block.
 * assumes one clock, the package offsets and a bind from the bench top.
 */
`timescale 1ns/1ps
`default_nettype none

module tic_capture_chk
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // register port
    input  wire tic_bus_req_t          busReq,
    input  wire logic [TIC_DATA_W-1:0] rdData,
    // pin and interrupt
    input  wire logic                  capturePin,
    input  wire logic                  timerIntReq
);
    logic       ctrlWr;
    logic       loRd;
    logic [7:0] lastCtl;
    logic [3:0] age;
    logic [3:0] quiet;

    // control writes and count low reads seen on the port
    assign ctrlWr = busReq.wr && busReq.addr == TIC_OFS_CTRL;
    assign loRd   = busReq.rd && busReq.addr == TIC_OFS_CNT_LO;

    // shadow of the last control write, clocks since a write or pin change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lastCtl <= 8'h00;
            age     <= 4'h0;
            quiet   <= 4'h0;
        end else begin
            if (ctrlWr) begin
                lastCtl <= busReq.wdata;
            end
            age   <= busReq.wr ? 4'h0 : age + {3'h0, age != 4'hF};
            quiet <= $changed(capturePin) ? 4'h0
                     : quiet + {3'h0, quiet != 4'hF};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reset_quiet: assert property ($rose(rst_b)
        |-> !timerIntReq && rdData == 8'h00)
        else $error("outputs not idle after reset");
    a_rd_idle: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
        else $error("read data outside a read answer");
    a_rd_unmapped: assert property (busReq.rd && busReq.addr > TIC_OFS_CAP_HI
        |=> rdData == 8'h00) else $error("unmapped offset read not zero");
    a_ctrl_spare: assert property (busReq.rd && busReq.addr == TIC_OFS_CTRL
        |=> rdData[1:0] == 2'b00) else $error("spare control bits not zero");
    a_int_masked: assert property (
        timerIntReq |-> lastCtl[TIC_BIT_IRQEN])
        else $error("interrupt while disabled");
    a_flag_clear: assert property (ctrlWr
        && !busReq.wdata[TIC_BIT_MODE_LO]
        && !busReq.wdata[TIC_BIT_CAPPND] && quiet > 4'h4 |=> !timerIntReq [*2])
        else $error("cleared flag still requests");
    a_edge_int: assert property (
        lastCtl[7:6] == 2'b01
        && lastCtl[TIC_BIT_IRQEN] && (lastCtl[TIC_BIT_EDGE] ? $fell(capturePin)
        : $rose(capturePin)) ##1 !ctrlWr [*5] |-> timerIntReq)
        else $error("selected edge raised no interrupt");
    a_count_down: assert property (
        lastCtl[7:6] == 2'b01 && age > 4'h2
        && loRd ##1 loRd |=> rdData == $past(rdData) - 8'h01)
        else $error("count not stepping down by one");
    a_count_hold: assert property (
        !lastCtl[TIC_BIT_MODE_LO] && age > 4'h2
        && loRd ##1 loRd |=> rdData == $past(rdData))
        else $error("count moves while halted");
endmodule

`default_nettype wire

// ---- testbench/tic_pin_src.sv ----
/*
 * model of the external source on the capture input pin.
 * assumes calls right after a rising clock edge; it always drives.
 */
`timescale 1ns/1ps
`default_nettype none

module tic_pin_src (
    // clock
    input  wire logic clk_sys,
    // capture input pin, only ever driven from this side
    output var  logic pin
);
    logic prev;
    int   held;

    // idle low at time zero
    initial begin
        pin  = 1'b0;
        prev = 1'b0;
        held = 2;
    end

    // count clocks since the level last changed
    always @(posedge clk_sys) begin
        held <= (pin != prev) ? 0 : held + 1;
        prev <= pin;
    end

    // a level stands a full clock before it may change again
    task automatic setLevel(input logic lvl);
        while (held < 1) @(posedge clk_sys);
        pin <= lvl;
    endtask
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
/*
 * self-checking bench of the timer input capture block.
 * assumes the pin source model and the checker file are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
    import tic_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         rst_b   = 1'b0;
    tic_bus_req_t busReq  = '0;
    logic [7:0]   rdData;
    logic         capturePin;
    logic         timerIntReq;
    logic         rdPend  = 1'b0;
    logic [7:0]   lastRd;
    logic [15:0]  note;
    logic [15:0]  noteQ[$];
    int           err_count = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    int unsigned  rs = 27414;

    tic_capture tic_capture_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq),
        .rdData(rdData), .capturePin(capturePin), .timerIntReq(timerIntReq));
    tic_pin_src tic_pin_src_inst (.clk_sys(clk_sys), .pin(capturePin));

    // 10 MHz clock
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // cycle count and hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            complete_run();
        end
    end

    // answers to reads are compared with the oldest note
    always @(posedge clk_sys) rdPend <= busReq.rd;
    always @(negedge clk_sys) begin
        if (rdPend) begin
            note = noteQ.pop_front();
            lastRd = rdData;
            if (note[15:8] != 8'h00) check(((rdData ^ note[7:0]) & note[15:8])
                === 8'h00, "read data mismatch");
        end
    end

    function automatic int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic at(input int t);
        do @(posedge clk_sys); while (cyc < t);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
    endtask

    // n back-to-back reads of one offset, mask m and value v noted
    task automatic rd(input logic [2:0] a, input int n, input logic [7:0] m,
                      input logic [7:0] v);
        repeat (n) begin
            @(posedge clk_sys);
            busReq <= '{a, 8'h00, 1'b0, 1'b1};
            noteQ.push_back({m, v});
        end
        @(posedge clk_sys);
        busReq.rd <= 1'b0;
    endtask

    task automatic rd16(input logic [2:0] a, input logic [15:0] v);
        rd(a, 1, 8'hFF, v[7:0]);
        rd(a + 3'h1, 1, 8'hFF, v[15:8]);
    endtask

    task automatic rdGet(input logic [2:0] a, output logic [15:0] v);
        rd(a, 1, 8'h00, 8'h00);
        @(negedge clk_sys);
        #1 v[7:0] = lastRd;
        rd(a + 3'h1, 1, 8'h00, 8'h00);
        @(negedge clk_sys);
        #1 v[15:8] = lastRd;
    endtask

    task automatic intChk(input logic v);
        @(negedge clk_sys);
        check(timerIntReq === v, "interrupt request level wrong");
    endtask

    // two selected edges n clocks apart in standard capture
    task automatic stdPair(input logic f, input int n);
        logic [15:0] c1;
        logic [7:0]  cw;
        int          t0;
        cw = {2'b01, f, 5'b00100};
        wr(TIC_OFS_CTRL, cw);
        tic_pin_src_inst.setLevel(f);
        t0 = cyc + 8;
        at(t0);
        tic_pin_src_inst.setLevel(!f);
        at(t0 + 8);
        intChk(1'b1);
        rd(TIC_OFS_CTRL, 1, 8'hFF, cw | 8'h08);
        rdGet(TIC_OFS_CAP_LO, c1);
        wr(TIC_OFS_CTRL, cw);
        intChk(1'b0);
        at(t0 + n / 2);
        tic_pin_src_inst.setLevel(f);
        at(t0 + n);
        tic_pin_src_inst.setLevel(!f);
        at(t0 + n + 8);
        rd16(TIC_OFS_CAP_LO, c1 - 16'(n));
        wr(TIC_OFS_CTRL, cw);
        $display("standard capture edge %0d done", f);
    endtask

    // main sequence
    initial begin
        logic        s;
        logic        e;
        int          a;
        int          b;
        int          d;
        int          t0;
        logic [7:0]  cw;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(TIC_OFS_CTRL, 1, 8'hFF, TIC_CTRL_RST);
        rd16(TIC_OFS_CNT_LO, TIC_CNT_RST);
        rd16(TIC_OFS_CAP_LO, TIC_CAP_RST);
        rd(3'h5, 1, 8'hFF, TIC_RD_RST);
        intChk(1'b0);
        $display("reset values done");
        wr(TIC_OFS_CNT_LO, 8'hFF);
        wr(TIC_OFS_CNT_HI, 8'hFF);
        stdPair(1'b0, 40 + int'(rnd() % 32));
        stdPair(1'b1, 40 + int'(rnd() % 32));
        wr(TIC_OFS_CTRL, 8'h80);
        repeat (4) @(posedge clk_sys);
        rd(TIC_OFS_CNT_LO, 2, 8'h00, 8'h00);
        wr(TIC_OFS_CNT_LO, 8'h10);
        wr(TIC_OFS_CNT_HI, 8'h00);
        wr(TIC_OFS_CTRL, 8'h54);
        t0 = cyc;
        repeat (4) @(posedge clk_sys);
        rd(TIC_OFS_CNT_LO, 2, 8'h00, 8'h00);
        // rising edge timed so its capture lands with the underflow
        at(t0 + 14);
        tic_pin_src_inst.setLevel(1'b1);
        at(t0 + 30);
        rd(TIC_OFS_CTRL, 1, 8'hFF, 8'h5C);
        rd16(TIC_OFS_CAP_LO, 16'h0000);
        intChk(1'b1);
        wr(TIC_OFS_CTRL, 8'h50);
        intChk(1'b0);
        rd(TIC_OFS_CTRL, 1, 8'hFF, 8'h50);
        wr(TIC_OFS_CTRL, 8'h44);
        rd(TIC_OFS_CTRL, 1, 8'hFF, 8'h44);
        $display("underflow done");
        for (int p = 0; p < 4; p++) begin
            s = p[1];
            e = p[0];
            a = 3 + int'(rnd() % 32);
            b = 3 + int'(rnd() % 32);
            d = (s == e) ? a + b : a;
            cw = {2'b11, s, e, 4'b0100};
            wr(TIC_OFS_CTRL, 8'h00);
            tic_pin_src_inst.setLevel(s);
            wr(TIC_OFS_CTRL, cw);
            t0 = cyc + 6;
            at(t0);
            tic_pin_src_inst.setLevel(!s);
            at(t0 + a);
            tic_pin_src_inst.setLevel(s);
            if (s == e) begin
                at(t0 + a + b);
                tic_pin_src_inst.setLevel(!s);
            end
            at(t0 + d + 8);
            rd16(TIC_OFS_CAP_LO, 16'(d - 1));
            rd(TIC_OFS_CTRL, 1, 8'hFF, {2'b11, s, 5'b01100});
            intChk(1'b1);
            $display("difference pairing %0d done", p);
        end
        complete_run();
    end
endmodule

bind tic_capture tic_capture_chk tic_capture_chk_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
    .capturePin(capturePin), .timerIntReq(timerIntReq));

`default_nettype wire
